// File: logic/rsq_sequencer.sv
// Reset and STOP release sequencer: reset sources, stabilisation wait,
// wake decision, vector load and the after-reset register bank.
// Assumes all inputs are synchronous to CLK, which stands for fx.
`timescale 1ns/10ps
`default_nettype none
module rsq_sequencer
#(
    parameter int STAB_CYCLES = rsq_pkg::STAB_COUNT
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic RESET_PIN_N,
    input wire logic WDT_OVF,
    input wire logic STOP_ENTER,
    input wire rsq_pkg::rsq_int_t INT_WAKE,
    input wire logic TEST_REQ,
    input wire logic TEST_MASK,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] MEM_RDATA,
    output logic [7:0] RDATA,
    output logic [15:0] MEM_ADDR,
    output logic MEM_RD,
    output logic [15:0] PC,
    output logic PC_VALID,
    output logic CPU_RUN,
    output logic IN_STOP,
    output logic PIN_HIZ,
    output logic MAIN_OSC_EN,
    output logic SUB_OSC_EN,
    output logic RESUME_NEXT,
    output logic VECTOR_INT,
    output logic RAM_KEPT,
    output logic [7:0] PORT0_OUT,
    output logic [7:0] PORT0_OE
);
    import rsq_pkg::*;

    rsq_state_t state;
    rsq_state_t next_state;
    logic rst_req;
    logic int_go;
    logic test_go;
    logic int_vec;
    logic wake_vec;
    logic wdt_src;
    logic [STAB_W-1:0] stab_cnt;
    logic stab_done;
    logic rst_done;
    logic fetch_start;
    logic fetch_done;
    logic [15:0] fetch_pc;
    logic next_hiz;
    logic [7:0] bank [NREG];
    logic [7:0] status;

    // Both sources feed one request; wdt_src records a watchdog cause for the status register.
    assign rst_req = !RESET_PIN_N || WDT_OVF;
    assign int_go = INT_WAKE.req && !INT_WAKE.interrupt_mask_flag;
    assign int_vec = INT_WAKE.interrupt_accept_enable
        && (!INT_WAKE.interrupt_priority_flag
        || INT_WAKE.in_service_priority_flag);
    assign test_go = TEST_REQ && !TEST_MASK;
    assign stab_done = stab_cnt == STAB_W'(STAB_CYCLES - 1);
    assign rst_done = state == ST_WAIT_RST && stab_done && !rst_req;
    assign next_hiz = next_state == ST_RESET || next_state == ST_WAIT_RST;

    always_comb
    begin
        next_state = state;
        if (rst_req)
        begin
            next_state = ST_RESET;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (STOP_ENTER)
                    begin
                        next_state = ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    if (int_go || test_go)
                    begin
                        next_state = ST_WAIT_WAKE;
                    end
                end
                ST_RESET:
                begin
                    // A watchdog request is one pulse, so this releases itself.
                    next_state = ST_WAIT_RST;
                end
                ST_WAIT_RST:
                begin
                    if (stab_done)
                    begin
                        next_state = ST_VEC;
                    end
                end
                ST_WAIT_WAKE:
                begin
                    if (stab_done)
                    begin
                        next_state = ST_RUN;
                    end
                end
                ST_VEC:
                begin
                    if (fetch_done)
                    begin
                        next_state = ST_RUN;
                    end
                end
                default:
                begin
                    next_state = ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state <= ST_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // The count starts from zero on the first wait cycle after release.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || (state != ST_WAIT_RST && state != ST_WAIT_WAKE))
        begin
            stab_cnt <= '0;
        end
        else if (!stab_done)
        begin
            stab_cnt <= stab_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            wake_vec <= 1'b0;
        end
        else if (state == ST_STOP && !rst_req && (int_go || test_go))
        begin
            // An accepted interrupt outranks a test input in the same cycle.
            wake_vec <= int_go && int_vec;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            RESUME_NEXT <= 1'b0;
            VECTOR_INT <= 1'b0;
        end
        else
        begin
            RESUME_NEXT <= state == ST_WAIT_WAKE && stab_done && !rst_req
                && !wake_vec;
            VECTOR_INT <= state == ST_WAIT_WAKE && stab_done && !rst_req
                && wake_vec;
        end
    end

    // The stop flag survives a reset and falls only when the wait is over.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            IN_STOP <= 1'b0;
        end
        else if (state == ST_RUN && STOP_ENTER && !rst_req)
        begin
            IN_STOP <= 1'b1;
        end
        else if ((state == ST_WAIT_RST || state == ST_WAIT_WAKE) && stab_done
            && !rst_req)
        begin
            IN_STOP <= 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            RAM_KEPT <= 1'b0;
            wdt_src <= 1'b0;
        end
        else if (rst_req && state != ST_RESET)
        begin
            RAM_KEPT <= IN_STOP;
            wdt_src <= WDT_OVF && RESET_PIN_N;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PIN_HIZ <= 1'b1;
            MAIN_OSC_EN <= 1'b0;
            SUB_OSC_EN <= 1'b1;
            CPU_RUN <= 1'b0;
        end
        else
        begin
            PIN_HIZ <= next_hiz;
            MAIN_OSC_EN <= next_state != ST_RESET && next_state != ST_STOP;
            SUB_OSC_EN <= 1'b1;
            CPU_RUN <= next_state == ST_RUN;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            fetch_start <= 1'b0;
        end
        else
        begin
            fetch_start <= rst_done;
        end
    end

    rsq_vec_fetch u_fetch
    (
        .clk(CLK),
        .sys_rst(SYS_RST),
        .abort(rst_req),
        .start(fetch_start),
        .mem_rdata(MEM_RDATA),
        .mem_addr(MEM_ADDR),
        .mem_rd(MEM_RD),
        .pc(fetch_pc),
        .done(fetch_done)
    );

    // The counter goes undefined across a reset; RAM does too unless the reset came during STOP.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PC <= 16'h0000;
            PC_VALID <= 1'b0;
        end
        else if (fetch_done && !rst_req)
        begin
            PC <= fetch_pc;
            PC_VALID <= 1'b1;
        end
        else if (next_state == ST_RESET || next_state == ST_WAIT_RST)
        begin
            PC_VALID <= 1'b0;
        end
    end

    // Reset values land only when the reset completes; software writes are
    // refused while the processor is held.
    for (genvar i = 0; i < NREG; i++)
    begin : g_bank
        always_ff @(posedge CLK)
        begin
            if (SYS_RST)
            begin
                bank[i] <= RST_VAL[i];
            end
            else if (rst_done && HAS_RST[i])
            begin
                bank[i] <= RST_VAL[i];
            end
            else if (WR && CPU_RUN && ADDR == BANK_BASE + 8'(i))
            begin
                bank[i] <= WDATA;
            end
        end
    end

    always_comb
    begin
        status = 8'h00;
        status[ST_B_RUN] = CPU_RUN;
        status[ST_B_STOP] = IN_STOP;
        status[ST_B_PCV] = PC_VALID;
        status[ST_B_WDT] = wdt_src;
        status[ST_B_RAM] = RAM_KEPT;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !RD)
        begin
            RDATA <= 8'h00;
        end
        else if (ADDR >= BANK_BASE && ADDR < BANK_BASE + 8'(NREG))
        begin
            RDATA <= bank[6'(ADDR - BANK_BASE)];
        end
        else if (ADDR == STAT_ADDR)
        begin
            RDATA <= status;
        end
        else
        begin
            RDATA <= 8'h00;
        end
    end

    // A direction bit of one makes the pin an input.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            PORT0_OUT <= 8'h00;
            PORT0_OE <= 8'h00;
        end
        else
        begin
            PORT0_OUT <= bank[IDX_P0];
            PORT0_OE <= next_hiz ? 8'h00 : ~bank[IDX_PM0];
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    logic [STAB_W-1:0] wait_len;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST || state != ST_WAIT_RST)
        begin
            wait_len <= '0;
        end
        else
        begin
            wait_len <= wait_len + 1'b1;
        end
    end

    sequence s_stop_rst;
        state == ST_STOP && rst_req;
    endsequence

    sequence s_int_release;
        state == ST_STOP && !rst_req && int_go && int_vec ##1 state == ST_WAIT_WAKE;
    endsequence

    property p_stop_exit;
        $fell(IN_STOP) |-> $past(state == ST_WAIT_RST || state == ST_WAIT_WAKE);
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("stop left early");

    property p_int_hold;
        state == ST_STOP && !rst_req && INT_WAKE.req && INT_WAKE.interrupt_mask_flag
            && !test_go |=> state == ST_STOP;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("masked wake left stop");

    property p_int_vec;
        s_int_release |-> wake_vec;
    endproperty
    a_int_vec: assert property (p_int_vec) else $error("wake decision lost");

    property p_test_hold;
        state == ST_STOP && !rst_req && !int_go && TEST_REQ && TEST_MASK
            |=> state == ST_STOP;
    endproperty
    a_test_hold: assert property (p_test_hold) else $error("masked test left stop");

    property p_rst_hiz;
        rst_req |=> state == ST_RESET && PIN_HIZ && !CPU_RUN;
    endproperty
    a_rst_hiz: assert property (p_rst_hiz) else $error("reset not applied");

    property p_vector;
        fetch_done && !rst_req |=> PC == $past(fetch_pc) && PC_VALID;
    endproperty
    a_vector: assert property (p_vector) else $error("vector not loaded");

    property p_stab_len;
        rst_done |-> wait_len == STAB_W'(STAB_CYCLES - 1);
    endproperty
    a_stab_len: assert property (p_stab_len) else $error("wait length wrong");

    property p_wdt_release;
        WDT_OVF && RESET_PIN_N ##1 RESET_PIN_N && !WDT_OVF |=> state == ST_WAIT_RST;
    endproperty
    a_wdt_release: assert property (p_wdt_release) else $error("watchdog reset stuck");

    property p_osc;
        state == ST_RESET |-> !MAIN_OSC_EN && SUB_OSC_EN;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillators wrong in reset");

    property p_stop_kept;
        s_stop_rst |=> IN_STOP && PIN_HIZ && RAM_KEPT;
    endproperty
    a_stop_kept: assert property (p_stop_kept) else $error("stop state lost");

    property p_bank_still;
        state == ST_WAIT_RST && !stab_done |=> $stable(bank[IDX_PM0]) && !PC_VALID;
    endproperty
    a_bank_still: assert property (p_bank_still) else $error("state changed in wait");

    property p_psw;
        rst_done |=> bank[IDX_PSW] == 8'h02 && bank[IDX_PM0] == 8'h1f;
    endproperty
    a_psw: assert property (p_psw) else $error("reset values wrong");

endmodule
`default_nettype wire

// File: logic/rsq_pkg.sv
// Constants, types and the reset table of the reset and STOP release sequencer.
// Assumes one 20 MHz clock that also stands for the main system clock fx.
package rsq_pkg;

    localparam int CLK_HZ = 20_000_000;
    // Stabilisation wait is printed as 2^17 periods of fx.
    localparam int STAB_EXP = 17;
    localparam int STAB_PERIODS = 2 ** STAB_EXP;
    // One clock cycle per fx period, so the count follows directly.
    localparam int STAB_COUNT = STAB_PERIODS * (CLK_HZ / CLK_HZ);
    localparam int STAB_W = STAB_EXP + 1;

    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

    // Bank entries, in address order from BANK_BASE: status word, port 0 latch,
    // port 0/1/7 direction, pull-up option, clock control, stabilisation select,
    // memory size, expansion RAM size, 16-bit timer count/clock/mode/output,
    // 8-bit timer count/clock/mode/output, serial clock select, serial mode,
    // bus control, auto transfer, interrupt timing, converter mode and input
    // select, display modes 0..2, watch clock select, watchdog mode, request
    // flags low/high, mask flags low/high, priority flags low/high, external
    // interrupt mode, sampling clock select; then stack pointer, 8-bit compare
    // and conversion result, which reset leaves alone.
    localparam int NREG = 41;
    localparam logic [7:0] BANK_BASE = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h40;
    localparam int IDX_PSW = 0;
    localparam int IDX_P0 = 1;
    localparam int IDX_PM0 = 2;
    localparam logic [NREG-1:0] HAS_RST = 41'h03f_ffff_ffff;
    localparam logic [7:0] RST_VAL [NREG] = '{
        8'h02, 8'h00, 8'h1f, 8'hff, 8'h1f, 8'h00, 8'h04, 8'h04, 8'hcf, 8'h0a,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h88, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00
    };

    // Status register bit positions.
    localparam int ST_B_RUN = 0;
    localparam int ST_B_STOP = 1;
    localparam int ST_B_PCV = 2;
    localparam int ST_B_WDT = 3;
    localparam int ST_B_RAM = 4;

    typedef struct packed {
        logic req;
        logic interrupt_mask_flag;
        logic interrupt_priority_flag;
        logic interrupt_accept_enable;
        logic in_service_priority_flag;
    } rsq_int_t;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_STOP,
        ST_RESET,
        ST_WAIT_RST,
        ST_WAIT_WAKE,
        ST_VEC
    } rsq_state_t;

endpackage

// File: logic/rsq_vec_fetch.sv
// Reset vector fetch: reads the low and high program counter bytes.
// Assumes program memory answers a read one cycle after the read strobe.
`timescale 1ns/10ps
`default_nettype none
module rsq_vec_fetch
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic abort,
    input wire logic start,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic [15:0] pc,
    output logic done
);
    import rsq_pkg::*;

    logic [1:0] step;

    always_ff @(posedge clk)
    begin
        if (sys_rst || abort)
        begin
            step <= 2'h0;
            mem_rd <= 1'b0;
            mem_addr <= VEC_LO_ADDR;
            done <= 1'b0;
            pc <= 16'h0000;
        end
        else
        begin
            done <= 1'b0;
            mem_rd <= 1'b0;
            case (step)
                2'h0:
                begin
                    if (start)
                    begin
                        mem_rd <= 1'b1;
                        mem_addr <= VEC_LO_ADDR;
                        step <= 2'h1;
                    end
                end
                2'h1:
                begin
                    mem_rd <= 1'b1;
                    mem_addr <= VEC_HI_ADDR;
                    step <= 2'h2;
                end
                2'h2:
                begin
                    pc[7:0] <= mem_rdata;
                    step <= 2'h3;
                end
                default:
                begin
                    pc[15:8] <= mem_rdata;
                    done <= 1'b1;
                    step <= 2'h0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: verification/rsq_reset_src.sv
// External reset circuit model that drives the active-low reset pin.
// Assumes the 20 MHz bench clock. The pin idles high through its pull-up.
`timescale 1ns/10ps
`default_nettype none
module rsq_reset_src
#(
    parameter int LOW_CYCLES = 200
)
(
    input wire logic clk,
    input wire logic go,
    output logic reset_pin_n
);
    logic [15:0] count = 16'h0000;

    // A shorter pulse would not be a valid reset, so each request lasts 10 us.
    assign reset_pin_n = (count == 16'h0000);

    always @(posedge clk)
    begin
        if (go)
            count <= 16'(LOW_CYCLES);
        else if (count != 16'h0000)
            count <= count - 16'h0001;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the reset and STOP release sequencer.
// Assumes the sequencer is built with a short stabilisation wait.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rsq_pkg::*;
    localparam int STAB = 8;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic WDT_OVF = 1'b0;
    logic STOP_ENTER = 1'b0;
    rsq_int_t INT_WAKE = '0;
    logic TEST_REQ = 1'b0;
    logic TEST_MASK = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] MEM_RDATA = 8'h00;
    logic go = 1'b0;
    logic RESET_PIN_N;
    logic [7:0] RDATA;
    logic [15:0] MEM_ADDR;
    logic MEM_RD;
    logic [15:0] PC;
    logic PC_VALID;
    logic CPU_RUN;
    logic IN_STOP;
    logic PIN_HIZ;
    logic MAIN_OSC_EN;
    logic SUB_OSC_EN;
    logic RESUME_NEXT;
    logic VECTOR_INT;
    logic RAM_KEPT;
    logic [7:0] PORT0_OUT;
    logic [7:0] PORT0_OE;
    int n_errors = 0;
    int checks_done = 0;
    logic rn;
    logic vi;
    logic exp_vec;

    always #25 CLK = ~CLK;

    // Released memory shows a changing pattern so a stale byte cannot pass.
    always @(posedge CLK)
        MEM_RDATA <= (MEM_RD === 1'b1) ? ((MEM_ADDR == 16'h0000) ? 8'h34 :
            (MEM_ADDR == 16'h0001) ? 8'h12 : 8'h5a) : ~MEM_RDATA;

    rsq_reset_src #(.LOW_CYCLES(200)) src_u (.clk(CLK), .go(go), .reset_pin_n(RESET_PIN_N));

    rsq_sequencer #(.STAB_CYCLES(STAB)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST),
        .RESET_PIN_N(RESET_PIN_N), .WDT_OVF(WDT_OVF), .STOP_ENTER(STOP_ENTER),
        .INT_WAKE(INT_WAKE), .TEST_REQ(TEST_REQ), .TEST_MASK(TEST_MASK), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .MEM_RDATA(MEM_RDATA), .RDATA(RDATA),
        .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .PC(PC), .PC_VALID(PC_VALID),
        .CPU_RUN(CPU_RUN), .IN_STOP(IN_STOP), .PIN_HIZ(PIN_HIZ), .MAIN_OSC_EN(MAIN_OSC_EN),
        .SUB_OSC_EN(SUB_OSC_EN), .RESUME_NEXT(RESUME_NEXT), .VECTOR_INT(VECTOR_INT),
        .RAM_KEPT(RAM_KEPT), .PORT0_OUT(PORT0_OUT), .PORT0_OE(PORT0_OE));

    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge CLK);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, {8'h00, exp}, {8'h00, d});
    endtask

    // Waits for the run state, counting the cycles with pins still released.
    // The exit from reset and five fetch cycles add six to the wait; skip is the wait cycles the caller has
    // already ticked through before calling.
    task automatic wait_run(input logic [7:0] status, input int skip);
        int cyc;
        int hz;
        cyc = 0;
        hz = 0;
        while (CPU_RUN !== 1'b1)
        begin
            tick();
            cyc++;
            if (PIN_HIZ === 1'b1)
                hz++;
            if (cyc > 1000)
            begin
                n_errors++;
                report_and_stop();
            end
        end
        chk("hiz through wait", 16'(STAB - skip), 16'(hz));
        chk("run delay", 16'(STAB + 6 - skip), 16'(cyc));
        chk("pc", 16'h1234, PC);
        chk("pc valid", 16'h1, {15'h0, PC_VALID});
        chk("pins driven", 16'h0, {15'h0, PIN_HIZ});
        chk("main osc", 16'h1, {15'h0, MAIN_OSC_EN});
        chk("port latch", 16'h0000, {8'h00, PORT0_OUT});
        // Direction 1FH leaves only the top three pins of port 0 driving.
        chk("port drive", 16'h00e0, {8'h00, PORT0_OE});
        rd_chk("status", STAT_ADDR, status);
    endtask

    // Checks the after-reset table; entries without a reset value hold other.
    task automatic check_bank(input logic [7:0] other);
        for (int i = 0; i < NREG; i++)
            rd_chk("bank", BANK_BASE + 8'(i), HAS_RST[i] ? RST_VAL[i] : other);
        rd_chk("unmapped", 8'h30, 8'h00);
    endtask

    // Pulls the pin low through the partner and probes the device meanwhile.
    task automatic pin_reset(input logic stop_exp);
        int n;
        @(posedge CLK);
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        repeat (5) tick();
        chk("hiz in reset", 16'h1, {15'h0, PIN_HIZ});
        chk("main osc in reset", 16'h0, {15'h0, MAIN_OSC_EN});
        chk("sub osc in reset", 16'h1, {15'h0, SUB_OSC_EN});
        chk("stop kept", {15'h0, stop_exp}, {15'h0, IN_STOP});
        chk("port oe", 16'h0, {8'h00, PORT0_OE});
        wr(8'(IDX_PSW), 8'h77);
        rd_chk("held in reset", 8'(IDX_PSW), 8'ha5);
        n = 0;
        while (RESET_PIN_N !== 1'b1 && n < 400)
        begin
            tick();
            n++;
        end
        if (n >= 400)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask

    task automatic enter_stop();
        @(posedge CLK);
        STOP_ENTER <= 1'b1;
        @(posedge CLK);
        STOP_ENTER <= 1'b0;
        tick();
        chk("in stop", 16'h1, {15'h0, IN_STOP});
    endtask

    task automatic wait_wake(output logic r, output logic v);
        r = 1'b0;
        v = 1'b0;
        repeat (STAB + 20)
        begin
            tick();
            if (RESUME_NEXT === 1'b1)
                r = 1'b1;
            if (VECTOR_INT === 1'b1)
                v = 1'b1;
        end
    endtask

    initial
    begin
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        wait_run(8'h05, 0);
        check_bank(8'h00);
        for (int i = 0; i < NREG; i++)
            wr(BANK_BASE + 8'(i), 8'ha5);
        pin_reset(1'b0);
        wait_run(8'h05, 0);
        check_bank(8'ha5);
        for (int i = 0; i < NREG; i++)
            wr(BANK_BASE + 8'(i), 8'ha5);
        @(posedge CLK);
        WDT_OVF <= 1'b1;
        @(posedge CLK);
        WDT_OVF <= 1'b0;
        tick();
        chk("hiz after watchdog", 16'h1, {15'h0, PIN_HIZ});
        wait_run(8'h0d, 1);
        check_bank(8'ha5);
        for (int k = 0; k < 8; k++)
        begin
            enter_stop();
            @(posedge CLK);
            INT_WAKE <= '{1'b1, 1'b0, k[2], k[1], k[0]};
            @(posedge CLK);
            INT_WAKE <= '0;
            wait_wake(rn, vi);
            exp_vec = k[1] & (~k[2] | k[0]);
            chk("vector", {15'h0, exp_vec}, {15'h0, vi});
            chk("resume", {15'h0, ~exp_vec}, {15'h0, rn});
        end
        enter_stop();
        @(posedge CLK);
        INT_WAKE <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        TEST_MASK <= 1'b1;
        TEST_REQ <= 1'b1;
        @(posedge CLK);
        INT_WAKE <= '0;
        TEST_REQ <= 1'b0;
        wait_wake(rn, vi);
        chk("masked wake", 16'h0, {14'h0, rn, vi});
        chk("stop held", 16'h1, {15'h0, IN_STOP});
        @(posedge CLK);
        TEST_MASK <= 1'b0;
        TEST_REQ <= 1'b1;
        @(posedge CLK);
        TEST_REQ <= 1'b0;
        wait_wake(rn, vi);
        chk("test wake", 16'h2, {14'h0, rn, vi});
        // Refill so the held-in-reset probe and the kept entries have a known value.
        for (int i = 0; i < NREG; i++)
            wr(BANK_BASE + 8'(i), 8'ha5);
        enter_stop();
        pin_reset(1'b1);
        wait_run(8'h15, 0);
        chk("ram kept", 16'h1, {15'h0, RAM_KEPT});
        chk("stop cleared", 16'h0, {15'h0, IN_STOP});
        check_bank(8'ha5);
        report_and_stop();
    end
endmodule
`default_nettype wire
